// *** src/radio_fifo_pkg.sv ***
// Operation
// - trigger 0 has 5-bit selector, zero never
// - code 1: read leaving data or first arrival
// - code 2: write leaving space or space freed
// - code 3 on empty, code 4 on full
// - code 5: length equals threshold after write
// - code 6: read while length equals threshold
// - codes 7-10: reset, release, discard, close
// - codes 11-16 never pulse
// - codes 17 upward repeat for transmit fifo
// - trigger 1 selector uses same code list
// - status bits 7 and 3: readable data present
// - status bits 5 and 1: level at or above threshold
// - status bits 4 and 0: fifo full
// - config bit 5: transmit auto frame close
// - config bit 4: transmit auto release
// - config bit 1: receive auto frame close
// - config bit 0: receive auto release
// - receive length register, 8 bits, resets zero
// - 7-bit receive threshold, resets zero
// - accepted write advances pointer modulo 128
// - discard restores write pointer to frame start
package radio_fifo_pkg;

  localparam int PTR_W = 7;
  localparam int SEL_W = 5;
  localparam int ADR_W = 18;

  // register indices; byte address is four times the index
  localparam logic [15:0] IDX_TRIG0_SEL = 16'h61c3;
  localparam logic [15:0] IDX_TRIG1_SEL = 16'h61c4;
  localparam logic [15:0] IDX_FLAGS = 16'h61c5;
  localparam logic [15:0] IDX_POLICY = 16'h61c6;
  localparam logic [15:0] IDX_RX_LEN = 16'h61c8;
  localparam logic [15:0] IDX_RX_THR = 16'h61c9;
  localparam logic [15:0] IDX_TX_LEN = 16'h61d0;
  localparam logic [15:0] IDX_TX_THR = 16'h61d1;

  // policy register fields and reset
  localparam int POL_TX_CLOSE = 5;
  localparam int POL_TX_REL = 4;
  localparam int POL_RX_CLOSE = 1;
  localparam int POL_RX_REL = 0;
  localparam logic [7:0] POLICY_RST = 8'h21;
  localparam logic [SEL_W-1:0] SEL_RST = 5'h00;
  localparam logic [PTR_W-1:0] THR_RST = 7'h00;
  localparam logic [PTR_W-1:0] FULL_LEVEL = 7'h7f;

  // condition codes, low nibble; bit 4 of a selector picks the transmit fifo
  localparam int COND_DATA = 1;
  localparam int COND_SPACE = 2;
  localparam int COND_EMPTY = 3;
  localparam int COND_FULL = 4;
  localparam int COND_THR_WR = 5;
  localparam int COND_THR_RD = 6;
  localparam int COND_RESET = 7;
  localparam int COND_RELEASE = 8;
  localparam int COND_DISCARD = 9;
  localparam int COND_CLOSE = 10;

  typedef struct packed {
    logic [PTR_W-1:0] wr;
    logic [PTR_W-1:0] rd;
    logic [PTR_W-1:0] frame_wr;
    logic [PTR_W-1:0] frame_rd;
  } fifo_ptr_type;

  typedef struct packed {
    logic wr;
    logic rd;
    logic clear;
    logic release_cmd;
    logic discard;
    logic close;
  } fifo_op_type;

endpackage : radio_fifo_pkg

// *** src/radio_fifo_status_dma_trigger.sv ***
`timescale 1ns/1ps
module radio_fifo_status_dma_trigger (
  input wire logic clk_i, // system clock, 20 MHz
  input wire logic rst_i, // synchronous reset, active high
  input wire logic ce_i, // clock enable, freezes all state when low
  input wire logic cyc_i, // wishbone cycle
  input wire logic stb_i, // wishbone strobe
  input wire logic we_i, // wishbone write enable
  input wire logic [radio_fifo_pkg::ADR_W-1:0] adr_i, // wishbone byte address
  input wire logic [3:0] sel_i, // wishbone byte selects
  input wire logic [31:0] dat_i, // wishbone write data
  output logic [31:0] dat_o, // wishbone read data
  output logic ack_o, // wishbone acknowledge
  input wire radio_fifo_pkg::fifo_op_type rx_op_i, // receive fifo operations
  input wire radio_fifo_pkg::fifo_op_type tx_op_i, // transmit fifo operations
  output logic rx_wr_accept_o, // receive write would be accepted
  output logic rx_rd_accept_o, // receive read would be accepted
  output logic tx_wr_accept_o, // transmit write would be accepted
  output logic tx_rd_accept_o, // transmit read would be accepted
  output logic dma_trig0_o, // radio dma trigger 0 pulse
  output logic dma_trig1_o // radio dma trigger 1 pulse
);
  import radio_fifo_pkg::*;

  // bytes allocated: from frame read start up to the write pointer
  function automatic logic [7:0] fill_len(input fifo_ptr_type s);
    fill_len = {1'b0, s.wr - s.frame_rd};
  endfunction : fill_len

  // bytes readable: only closed frames are visible to the reader
  function automatic logic readable(input fifo_ptr_type s);
    readable = (s.frame_wr != s.rd);
  endfunction : readable

  function automatic logic is_full(input fifo_ptr_type s);
    is_full = (s.wr - s.frame_rd) == FULL_LEVEL;
  endfunction : is_full

  // one cycle of pointer movement; clear wins over everything else
  function automatic fifo_ptr_type fifo_next(input fifo_ptr_type s, input fifo_op_type op,
                                             input logic auto_close, input logic auto_rel);
    fifo_ptr_type n;
    n = s;
    if (op.clear)
    begin
      n = '0;
    end
    else
    begin
      if (op.wr && !is_full(s))
      begin
        n.wr = s.wr + 7'h01;
      end
      if (op.rd && readable(s))
      begin
        n.rd = s.rd + 7'h01;
      end
      if (op.discard)
      begin
        n.wr = s.frame_wr;
      end
      if (op.close || auto_close)
      begin
        n.frame_wr = n.wr;
      end
      if (op.release_cmd || auto_rel)
      begin
        n.frame_rd = n.rd;
      end
    end
    fifo_next = n;
  endfunction : fifo_next

  // events of one cycle, indexed by the low nibble of a condition code
  function automatic logic [15:0] fifo_conds(input fifo_ptr_type s, input fifo_ptr_type n,
                                             input fifo_op_type op, input logic [PTR_W-1:0] thr);
    logic [15:0] c;
    logic wr_ok;
    logic rd_ok;
    c = '0;
    wr_ok = op.wr && !is_full(s) && !op.clear;
    rd_ok = op.rd && readable(s) && !op.clear;
    c[COND_DATA] = (rd_ok && readable(n)) || (wr_ok && fill_len(s) == 8'h00);
    c[COND_SPACE] = (wr_ok && !is_full(n)) || (is_full(s) && !is_full(n));
    c[COND_EMPTY] = (fill_len(n) == 8'h00) && (fill_len(s) != 8'h00);
    c[COND_FULL] = is_full(n) && !is_full(s);
    c[COND_THR_WR] = wr_ok && (fill_len(n) == {1'b0, thr});
    c[COND_THR_RD] = rd_ok && (fill_len(s) == {1'b0, thr});
    c[COND_RESET] = op.clear;
    c[COND_RELEASE] = op.release_cmd && !op.clear;
    c[COND_DISCARD] = op.discard && !op.clear;
    c[COND_CLOSE] = op.close && !op.clear;
    fifo_conds = c; // codes 0 and 11-15 stay zero
  endfunction : fifo_conds

  fifo_ptr_type rx_ptr;
  fifo_ptr_type tx_ptr;
  logic [SEL_W-1:0] trig0_condition;
  logic [SEL_W-1:0] trig1_condition;
  logic [7:0] fifo_pointer_policy;
  logic [PTR_W-1:0] rx_fill_threshold;
  logic [PTR_W-1:0] tx_fill_threshold;
  logic ack;
  logic [31:0] rdata;

  // bus decode
  wire logic [15:0] word_idx = adr_i[ADR_W-1:2];
  wire logic req = cyc_i && stb_i;
  wire logic wr_take = req && we_i && ack && sel_i[0];
  wire logic hit_trig0 = word_idx == IDX_TRIG0_SEL;
  wire logic hit_trig1 = word_idx == IDX_TRIG1_SEL;
  wire logic hit_flags = word_idx == IDX_FLAGS;
  wire logic hit_policy = word_idx == IDX_POLICY;
  wire logic hit_rx_len = word_idx == IDX_RX_LEN;
  wire logic hit_rx_thr = word_idx == IDX_RX_THR;
  wire logic hit_tx_len = word_idx == IDX_TX_LEN;
  wire logic hit_tx_thr = word_idx == IDX_TX_THR;

  // status flags from current pointers
  wire logic rx_empty_flag = fill_len(rx_ptr) == 8'h00;
  wire logic tx_empty_flag = fill_len(tx_ptr) == 8'h00;
  wire logic rx_readable = readable(rx_ptr);
  wire logic tx_readable = readable(tx_ptr);
  wire logic rx_full_flag = is_full(rx_ptr);
  wire logic tx_full_flag = is_full(tx_ptr);
  wire logic rx_level_reached = fill_len(rx_ptr) >= {1'b0, rx_fill_threshold};
  wire logic tx_level_reached = fill_len(tx_ptr) >= {1'b0, tx_fill_threshold};
  wire logic [7:0] fifo_flags = {tx_readable, tx_empty_flag, tx_level_reached, tx_full_flag,
                                 rx_readable, rx_empty_flag, rx_level_reached,
                                 rx_full_flag};

  wire logic [7:0] rx_fill_length = fill_len(rx_ptr);
  wire logic [7:0] tx_fill_length = fill_len(tx_ptr);

  // policy reserved bits are masked at write time, so the register reads back as held
  wire logic [7:0] rd_byte =
    hit_trig0 ? {3'h0, trig0_condition} :
    hit_trig1 ? {3'h0, trig1_condition} :
    hit_flags ? fifo_flags :
    hit_policy ? fifo_pointer_policy :
    hit_rx_len ? rx_fill_length :
    hit_rx_thr ? {1'b0, rx_fill_threshold} :
    hit_tx_len ? tx_fill_length :
    hit_tx_thr ? {1'b0, tx_fill_threshold} :
    8'h00; // unmapped and reserved bits read zero

  // next pointers and events
  wire logic rx_auto_frame_close = fifo_pointer_policy[POL_RX_CLOSE];
  wire logic rx_auto_release = fifo_pointer_policy[POL_RX_REL];
  wire logic tx_auto_frame_close = fifo_pointer_policy[POL_TX_CLOSE];
  wire logic tx_auto_release = fifo_pointer_policy[POL_TX_REL];
  wire fifo_ptr_type next_rx_ptr = fifo_next(rx_ptr, rx_op_i, rx_auto_frame_close,
                                             rx_auto_release);
  wire fifo_ptr_type next_tx_ptr = fifo_next(tx_ptr, tx_op_i, tx_auto_frame_close,
                                             tx_auto_release);
  wire logic [15:0] rx_conds = fifo_conds(rx_ptr, next_rx_ptr, rx_op_i, rx_fill_threshold);
  wire logic [15:0] tx_conds = fifo_conds(tx_ptr, next_tx_ptr, tx_op_i, tx_fill_threshold);
  // bit 4 of the selector moves the same list to the transmit fifo
  wire logic [31:0] all_conds = {tx_conds, rx_conds};
  wire logic next_trig0 = all_conds[trig0_condition];
  wire logic next_trig1 = all_conds[trig1_condition];

  assign rx_wr_accept_o = !rx_full_flag;
  assign rx_rd_accept_o = rx_readable;
  assign tx_wr_accept_o = !tx_full_flag;
  assign tx_rd_accept_o = tx_readable;
  assign ack_o = ack;
  assign dat_o = rdata;

  // a held request is answered on every other edge; each edge between drops ack and lands any write
  wire logic bus_take = req && !ack;
  // one strobe per writable register; a write lands on the edge where ack is sampled
  wire logic wr_trig0 = wr_take && hit_trig0;
  wire logic wr_trig1 = wr_take && hit_trig1;
  wire logic wr_policy = wr_take && hit_policy;
  wire logic wr_rx_thr = wr_take && hit_rx_thr;
  wire logic wr_tx_thr = wr_take && hit_tx_thr;

  // wishbone: ack one cycle after the request, dropped the cycle after
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack <= 1'b0;
    end
    else if (ce_i)
    begin
      ack <= bus_take;
    end
  end

  // read data is taken with the request and stands until the next one
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rdata <= 32'h0000_0000;
    end
    else if (ce_i && bus_take)
    begin
      rdata <= {24'h00_0000, rd_byte};
    end
  end

  // software registers, one short block each
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      trig0_condition <= SEL_RST;
    end
    else if (ce_i && wr_trig0)
    begin
      trig0_condition <= dat_i[SEL_W-1:0];
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      trig1_condition <= SEL_RST;
    end
    else if (ce_i && wr_trig1)
    begin
      trig1_condition <= dat_i[SEL_W-1:0];
    end
  end

  // reserved bits never store, which keeps the read path a plain register
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      fifo_pointer_policy <= POLICY_RST;
    end
    else if (ce_i && wr_policy)
    begin
      fifo_pointer_policy <= dat_i[7:0] & 8'h33;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rx_fill_threshold <= THR_RST;
    end
    else if (ce_i && wr_rx_thr)
    begin
      rx_fill_threshold <= dat_i[PTR_W-1:0];
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      tx_fill_threshold <= THR_RST;
    end
    else if (ce_i && wr_tx_thr)
    begin
      tx_fill_threshold <= dat_i[PTR_W-1:0];
    end
  end

  // pointers move on every enabled edge; a refused operation leaves them as they are
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rx_ptr <= '0;
    end
    else if (ce_i)
    begin
      rx_ptr <= next_rx_ptr;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      tx_ptr <= '0;
    end
    else if (ce_i)
    begin
      tx_ptr <= next_tx_ptr;
    end
  end

  // triggers are registered so each pulse is one clean clock wide, at the cost of one cycle
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      dma_trig0_o <= 1'b0;
      dma_trig1_o <= 1'b0;
    end
    else if (ce_i)
    begin
      dma_trig0_o <= next_trig0;
      dma_trig1_o <= next_trig1;
    end
  end

endmodule : radio_fifo_status_dma_trigger

// *** tb/radio_fifo_status_dma_trigger_checker.sv ***
`timescale 1ns/1ps
module radio_fifo_status_dma_trigger_checker
  import radio_fifo_pkg::*;
(
  input wire logic clk_i, // clock
  input wire logic rst_i, // reset
  input wire logic ce_i, // clock enable
  input wire logic cyc_i, // bus cycle
  input wire logic stb_i, // bus strobe
  input wire logic we_i, // bus write
  input wire logic ack_o, // bus ack
  input wire logic [31:0] dat_o, // read data
  input wire radio_fifo_pkg::fifo_op_type rx_op_i, // rx ops
  input wire radio_fifo_pkg::fifo_op_type tx_op_i, // tx ops
  input wire logic rx_wr_accept_o, // rx not full
  input wire logic rx_rd_accept_o, // rx readable
  input wire logic dma_trig0_o, // trigger 0
  input wire logic dma_trig1_o // trigger 1
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_req;
    cyc_i && stb_i && !ack_o && ce_i;
  endsequence
  // a policy write reaches the pointers one cycle late, so causes are looked for two edges back
  wire logic cause = rx_op_i != 6'h00 || tx_op_i != 6'h00 || (cyc_i && stb_i && we_i);
  AST_ACK_AFTER_REQ: assert property (s_req |=> ack_o)
    else $error("ack missing after request");
  AST_ACK_ONE_CYCLE: assert property (ack_o && ce_i |=> !ack_o)
    else $error("ack longer than one cycle");
  AST_DATA_HIGH_ZERO: assert property (ack_o |-> dat_o[31:8] == 24'h0)
    else $error("read data upper bits set");
  AST_TRIG0_CAUSE: assert property (dma_trig0_o && $past(ce_i) |-> $past(cause) || $past(cause, 2))
    else $error("trigger 0 without cause");
  AST_TRIG1_CAUSE: assert property (dma_trig1_o && $past(ce_i) |-> $past(cause) || $past(cause, 2))
    else $error("trigger 1 without cause");
  AST_FULL_ONLY_BY_WRITE: assert property ($fell(rx_wr_accept_o) |-> $past(rx_op_i.wr))
    else $error("rx became full without a write");
  AST_FULL_HOLDS: assert property (!rx_wr_accept_o && ce_i && rx_op_i == 6'h20
    |=> !rx_wr_accept_o)
    else $error("refused write freed space");
  AST_READABLE_CAUSE: assert property ($rose(rx_rd_accept_o) |-> $past(cause) || $past(cause, 2))
    else $error("rx readable without cause");
  AST_RESET_STATE: assert property (disable iff (1'b0) rst_i |=> !ack_o && !dma_trig0_o
    && !dma_trig1_o && rx_wr_accept_o && !rx_rd_accept_o)
    else $error("bad state after reset");
endmodule : radio_fifo_status_dma_trigger_checker
bind radio_fifo_status_dma_trigger radio_fifo_status_dma_trigger_checker
  radio_fifo_status_dma_trigger_checker_i (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
  .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .ack_o(ack_o), .dat_o(dat_o),
  .rx_op_i(rx_op_i), .tx_op_i(tx_op_i), .rx_wr_accept_o(rx_wr_accept_o),
  .rx_rd_accept_o(rx_rd_accept_o), .dma_trig0_o(dma_trig0_o), .dma_trig1_o(dma_trig1_o));

// *** tb/radio_fifo_far_side.sv ***
`timescale 1ns/1ps
module radio_fifo_far_side
  import radio_fifo_pkg::*;
(
  input wire logic clk_i, // system clock
  input wire logic trig0_i, // dma trigger 0
  input wire logic trig1_i, // dma trigger 1
  output radio_fifo_pkg::fifo_op_type rx_op_o, // rx fifo operations
  output radio_fifo_pkg::fifo_op_type tx_op_o // tx fifo operations
);
  initial
  begin
    rx_op_o = 6'h00;
    tx_op_o = 6'h00;
  end
  // one-cycle operation; returns triggers in the answer cycle and the cycle after
  task automatic pulse(input fifo_op_type rx, input fifo_op_type tx,
    output logic [1:0] trig, output logic [1:0] after);
    @(posedge clk_i);
    rx_op_o <= rx;
    tx_op_o <= tx;
    @(posedge clk_i);
    rx_op_o <= 6'h00;
    tx_op_o <= 6'h00;
    #1 trig = {trig1_i, trig0_i};
    @(posedge clk_i);
    #1 after = {trig1_i, trig0_i};
  endtask : pulse
endmodule : radio_fifo_far_side

// *** tb/radio_fifo_status_dma_trigger_bench.sv ***
`timescale 1ns/1ps
module radio_fifo_status_dma_trigger_bench;
  import radio_fifo_pkg::*;
  localparam fifo_op_type WR = 6'h20;
  localparam fifo_op_type RD = 6'h10;
  localparam fifo_op_type CLR = 6'h08;
  localparam fifo_op_type DSC = 6'h02;
  localparam fifo_op_type CLS = 6'h01;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc_i = 1'b0;
  logic stb_i = 1'b0;
  logic we_i = 1'b0;
  logic [ADR_W-1:0] adr_i = '0;
  logic [3:0] sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0;
  logic [31:0] dat_o;
  logic ack_o, rx_wr_accept_o, rx_rd_accept_o, dma_trig0_o, dma_trig1_o;
  logic tx_wr_accept_o, tx_rd_accept_o;
  logic ce_i = 1'b1;
  fifo_op_type rx_op_i, tx_op_i;
  int fail_count = 0;
  int cmp_count = 0;
  logic [7:0] never_codes [5] = '{8'h00, 8'h0b, 8'h0c, 8'h0f, 8'h10};
  initial
  begin
    forever #25 clk_i = ~clk_i;
  end
  radio_fifo_status_dma_trigger radio_fifo_status_dma_trigger_i (.clk_i(clk_i), .rst_i(rst_i),
    .ce_i(ce_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
    .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .rx_op_i(rx_op_i), .tx_op_i(tx_op_i),
    .rx_wr_accept_o(rx_wr_accept_o), .rx_rd_accept_o(rx_rd_accept_o),
    .tx_wr_accept_o(tx_wr_accept_o), .tx_rd_accept_o(tx_rd_accept_o),
    .dma_trig0_o(dma_trig0_o), .dma_trig1_o(dma_trig1_o));
  radio_fifo_far_side radio_fifo_far_side_i (.clk_i(clk_i), .trig0_i(dma_trig0_o),
    .trig1_i(dma_trig1_o), .rx_op_o(rx_op_i), .tx_op_o(tx_op_i));
  task automatic report_and_stop;
    if (fail_count == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : report_and_stop
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wb(input logic w, input logic [15:0] idx, input logic [7:0] d,
    output logic [31:0] q);
    int n;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= {idx, 2'b00};
    sel_i <= 4'h1;
    dat_i <= {24'h0, d};
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (ack_o !== 1'b1 && n < 20);
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    if (ack_o !== 1'b1)
    begin
      fail_count++;
      $display("[ERR] %0t bus timeout", $time);
      report_and_stop();
    end
  endtask : wb
  task automatic wr(input logic [15:0] idx, input logic [7:0] d);
    logic [31:0] q;
    wb(1'b1, idx, d, q);
  endtask : wr
  task automatic rchk(input logic [15:0] idx, input logic [31:0] exp);
    logic [31:0] q;
    wb(1'b0, idx, 8'h00, q);
    chk(q, exp);
  endtask : rchk
  // exp is {trigger 1, trigger 0}; both must be gone one cycle later
  task automatic op(input fifo_op_type rx, input fifo_op_type tx, input logic [1:0] exp);
    logic [1:0] t, a;
    radio_fifo_far_side_i.pulse(rx, tx, t, a);
    chk({30'h0, t}, {30'h0, exp});
    chk({30'h0, a}, 32'h0);
  endtask : op
  initial
  begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    rchk(IDX_FLAGS, 32'h66);
    rchk(IDX_POLICY, 32'h21);
    rchk(IDX_RX_LEN, 32'h0);
    rchk(IDX_TRIG1_SEL, 32'h0);
    wr(IDX_FLAGS, 8'hff);
    rchk(IDX_FLAGS, 32'h66);
    wr(16'h6100, 8'h5a);
    rchk(16'h6100, 32'h0);
    wr(IDX_RX_THR, 8'h82);
    rchk(IDX_RX_THR, 32'h02);
    wr(IDX_TRIG0_SEL, 8'h01);
    wr(IDX_TRIG1_SEL, 8'h05);
    op(WR, 6'h00, 2'b01);
    op(WR, 6'h00, 2'b10);
    rchk(IDX_RX_LEN, 32'h2);
    rchk(IDX_FLAGS, 32'h62);
    wr(IDX_TRIG0_SEL, 8'h09);
    op(DSC, 6'h00, 2'b01);
    rchk(IDX_RX_LEN, 32'h0);
    wr(IDX_TRIG0_SEL, 8'h0a);
    op(WR, 6'h00, 2'b00);
    op(CLS, 6'h00, 2'b01);
    rchk(IDX_FLAGS, 32'h68);
    wr(IDX_RX_THR, 8'h01);
    wr(IDX_TRIG0_SEL, 8'h03);
    wr(IDX_TRIG1_SEL, 8'h06);
    op(RD, 6'h00, 2'b11);
    rchk(IDX_RX_LEN, 32'h0);
    wr(IDX_TRIG0_SEL, 8'h11);
    wr(IDX_TRIG1_SEL, 8'h17);
    op(6'h00, WR, 2'b01);
    chk({30'h0, tx_rd_accept_o, tx_wr_accept_o}, 32'h3);
    rchk(IDX_TX_LEN, 32'h1);
    wr(IDX_TX_THR, 8'h02);
    rchk(IDX_TX_THR, 32'h2);
    rchk(IDX_FLAGS, 32'h84);
    wr(IDX_TX_THR, 8'h00);
    op(6'h00, CLR, 2'b10);
    foreach (never_codes[i])
    begin
      wr(IDX_TRIG0_SEL, never_codes[i]);
      op(WR, 6'h00, 2'b00);
      op(CLR, 6'h00, 2'b00);
    end
    wr(IDX_TRIG0_SEL, 8'h01);
    @(posedge clk_i);
    ce_i <= 1'b0;
    op(WR, 6'h00, 2'b00);
    @(posedge clk_i);
    ce_i <= 1'b1;
    rchk(IDX_RX_LEN, 32'h0);
    wr(IDX_TRIG0_SEL, 8'h04);
    for (int i = 0; i < 127; i++)
      op(WR, 6'h00, {1'b0, i == 126});
    chk({31'h0, rx_wr_accept_o}, 32'h0);
    op(WR, 6'h00, 2'b00);
    rchk(IDX_RX_LEN, 32'h7f);
    rchk(IDX_FLAGS, 32'h63);
    wr(IDX_POLICY, 8'hff);
    rchk(IDX_POLICY, 32'h33);
    rchk(IDX_FLAGS, 32'h6b);
    report_and_stop();
  end
endmodule : radio_fifo_status_dma_trigger_bench
